// *** design/vtpg_defs.svh ***
// Purpose: Constants of the video test pattern generator
// Assumes: Included by its bare name
// Notes:   Definitions only
`ifndef VTPG_DEFS_SVH
`define VTPG_DEFS_SVH
// ----------------------------------------
// Bus word indices (byte address is four times the index)
// ----------------------------------------
`define VTPG_IDX_PAGE 10'h0b0
`define VTPG_IDX_OFFSET 10'h0b1
`define VTPG_IDX_DATA 10'h0b2
`define VTPG_PAGE_PGEN 8'h00
// ----------------------------------------
// Field offsets within the generator page
// ----------------------------------------
`define VTPG_OFS_STATUS 8'h00
`define VTPG_OFS_CTL 8'h01
`define VTPG_OFS_CFG 8'h02
`define VTPG_OFS_DI 8'h03
`define VTPG_OFS_LSIZE_HI 8'h04
`define VTPG_OFS_LSIZE_LO 8'h05
`define VTPG_OFS_BAR_HI 8'h06
`define VTPG_OFS_BAR_LO 8'h07
`define VTPG_OFS_ACT_HI 8'h08
`define VTPG_OFS_ACT_LO 8'h09
`define VTPG_OFS_TOT_HI 8'h0a
`define VTPG_OFS_TOT_LO 8'h0b
`define VTPG_OFS_PD_HI 8'h0c
`define VTPG_OFS_PD_LO 8'h0d
`define VTPG_OFS_VBP 8'h0e
`define VTPG_OFS_VFP 8'h0f
`define VTPG_OFS_BLK_HI4 4'h1
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define VTPG_CTL_EN 0
`define VTPG_CTL_SLOW 1
`define VTPG_CFG_FIXED 7
`define VTPG_CFG_NBAR_LSB 4
`define VTPG_CFG_BLK_LSB 0
`define VTPG_RST_BYTE 8'h00
`define VTPG_RST_WORD 16'h0000
// ----------------------------------------
// Colour bar bytes
// ----------------------------------------
`define VTPG_BAR0 8'haa
`define VTPG_BAR1 8'h33
`define VTPG_BAR2 8'hf0
`define VTPG_BAR3 8'h7f
`define VTPG_BAR4 8'h55
`define VTPG_BAR5 8'hcc
`define VTPG_BAR6 8'h0f
`define VTPG_BAR7 8'h80
// ----------------------------------------
// Timing
// ----------------------------------------
`define VTPG_CLK_MHZ 125
`define VTPG_UNIT_NS 10
`define VTPG_UNIT_SLOW_NS 20
`define VTPG_CLK_NS (1000 / `VTPG_CLK_MHZ)
// ----------------------------------------
// Packet format
// ----------------------------------------
`define VTPG_DT_FS 6'h00
`define VTPG_DT_FE 6'h01
`define VTPG_CRC_INIT 16'hffff
`define VTPG_CRC_POLY 16'h8408
`define VTPG_ECC_P0 24'hf12cb7
`define VTPG_ECC_P1 24'hf2555b
`define VTPG_ECC_P2 24'h749a6d
`define VTPG_ECC_P3 24'hb8e38e
`define VTPG_ECC_P4 24'hdf03f0
`define VTPG_ECC_P5 24'heffc00
`endif

// *** design/vtpg_pkg.sv ***
// Purpose: Types of the video test pattern generator
// Assumes: Nothing
// Notes:   Constants live in vtpg_defs.svh
package vtpg_pkg;
   typedef struct packed {
      logic [7:0] ctl;
      logic [7:0] cfg;
      logic [7:0] di;
      logic [15:0] lsize;
      logic [15:0] bar;
      logic [15:0] act;
      logic [15:0] tot;
      logic [15:0] pd;
      logic [7:0] vbp;
      logic [7:0] vfp;
   } vtpg_cfg_t;
   typedef struct packed {
      logic valid;
      logic sop;
      logic eop;
      logic [7:0] data;
   } vtpg_byte_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_WAIT = 3'b001,
      ST_HDR = 3'b010,
      ST_PAY = 3'b011,
      ST_CRC = 3'b100
   } vtpg_state_t;
endpackage : vtpg_pkg

// *** design/vtpg_blk_mem.sv ***
// Purpose: Sixteen byte fixed colour block store
// Assumes: One write and one read port
// Notes:   Read data comes from a register
`timescale 1ns/1ps
`default_nettype none
module vtpg_blk_mem import vtpg_pkg::*; (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Write port
   input wire logic we_i,
   input wire logic [3:0] waddr_i,
   input wire logic [7:0] wdata_i,
   // Read port
   input wire logic [3:0] raddr_i,
   output logic [7:0] rdata_o
);
`include "vtpg_defs.svh"
   logic [7:0] mem_q [16];
   logic [7:0] mem_d [16];
   logic [7:0] rdata_q, rdata_d;
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi++) begin : g_byte
         always_comb begin
            mem_d[gi] = (we_i && waddr_i == 4'(gi)) ? wdata_i : mem_q[gi];
         end
         always_ff @(posedge clk_i) begin
            mem_q[gi] <= rst_i ? `VTPG_RST_BYTE : mem_d[gi];
         end
      end
   endgenerate
   always_comb begin
      rdata_d = mem_q[raddr_i];
   end
   always_ff @(posedge clk_i) begin
      rdata_q <= rst_i ? `VTPG_RST_BYTE : rdata_d;
   end
   assign rdata_o = rdata_q;
endmodule : vtpg_blk_mem
`default_nettype wire

// *** design/vtpg_crc16.sv ***
// Purpose: Byte serial payload checksum
// Assumes: Bits enter least significant first
// Notes:   Clear has priority over update
`timescale 1ns/1ps
`default_nettype none
module vtpg_crc16 import vtpg_pkg::*; (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Data
   input wire logic clear_i,
   input wire logic en_i,
   input wire logic [7:0] data_i,
   output logic [15:0] crc_o
);
`include "vtpg_defs.svh"
   logic [15:0] crc_q, crc_d;
   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         r = (r[0] ^ d[i]) ? ((r >> 1) ^ `VTPG_CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction : crc_byte
   always_comb begin
      crc_d = crc_q;
      if (clear_i) begin
         crc_d = `VTPG_CRC_INIT;
      end else if (en_i) begin
         crc_d = crc_byte(crc_q, data_i);
      end
   end
   always_ff @(posedge clk_i) begin
      crc_q <= rst_i ? `VTPG_CRC_INIT : crc_d;
   end
   assign crc_o = crc_q;
endmodule : vtpg_crc16
`default_nettype wire

// *** design/vtpg_top.sv ***
// Purpose: Video test pattern generator feeding the serial camera transmitter
// Assumes: clk_i is the transmit clock at 125 MHz, one byte per clock
// Notes:   Registers reached through a paged indirect window on Wishbone
//
// Notes on behaviour
// - Bars one to three: 0xAA, 0x33, 0xF0
// - Bars four to six: 0x7F, 0x55, 0xCC
// - Bar seven 0x0F, bar eight 0x80; last enabled bar fills line
// - One, two, four or eight leading bars
// - Line length and bar width are programmable
// - Line headers carry programmed data type and channel
// - Active and total lines set frame length
// - Front porch blank lines before frame end
// - Back porch blank lines after frame start
// - Period unit 10 ns, 20 ns at slow rate
// - Runs on transmit clock, emits formatted packets
// - Colour bar or fixed colour pattern selectable
// - Fixed colour uses same frame geometry fields
// - Fixed colour bars alternate block and complement
// - Block up to sixteen bytes, repeats along line
// - Sixteen byte registers hold block values
// - Configuration lives on indirect page zero
//
// The implementer's own choices: the address map and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module vtpg_top import vtpg_pkg::*; (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Packet stream to the transmitter
   output vtpg_byte_t pkt_o
);
`include "vtpg_defs.svh"
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [5:0] ecc6(input logic [23:0] h);
      return {^(h & `VTPG_ECC_P5), ^(h & `VTPG_ECC_P4), ^(h & `VTPG_ECC_P3),
              ^(h & `VTPG_ECC_P2), ^(h & `VTPG_ECC_P1), ^(h & `VTPG_ECC_P0)};
   endfunction : ecc6
   function automatic logic [31:0] hdr_word(input logic [7:0] di, input logic [15:0] wc);
      return {2'b00, ecc6({wc, di}), wc, di};
   endfunction : hdr_word
   function automatic logic [7:0] bar_byte(input logic [2:0] b);
      logic [7:0] v;
      unique case (b)
         3'h0: v = `VTPG_BAR0;
         3'h1: v = `VTPG_BAR1;
         3'h2: v = `VTPG_BAR2;
         3'h3: v = `VTPG_BAR3;
         3'h4: v = `VTPG_BAR4;
         3'h5: v = `VTPG_BAR5;
         3'h6: v = `VTPG_BAR6;
         3'h7: v = `VTPG_BAR7;
      endcase
      return v;
   endfunction : bar_byte
   // ----------------------------------------
   // Register window
   // ----------------------------------------
   vtpg_cfg_t cfg_q, cfg_d;
   logic [7:0] page_q, page_d, off_q, off_d;
   logic ack_q, ack_d;
   logic [31:0] dat_q, dat_d;
   logic req, wr_lane, data_wr, mem_we;
   logic [9:0] idx;
   logic [7:0] field_rd;
   vtpg_state_t st_q, st_d;
   always_comb begin
      req = wb_cyc_i && wb_stb_i && !ack_q;
      idx = wb_adr_i[11:2];
      wr_lane = req && wb_we_i && wb_sel_i[0];
      data_wr = wr_lane && idx == `VTPG_IDX_DATA && page_q == `VTPG_PAGE_PGEN;
      mem_we = data_wr && off_q[7:4] == `VTPG_OFS_BLK_HI4;
      page_d = (wr_lane && idx == `VTPG_IDX_PAGE) ? wb_dat_i[7:0] : page_q;
      off_d = (wr_lane && idx == `VTPG_IDX_OFFSET) ? wb_dat_i[7:0] : off_q;
      cfg_d = cfg_q;
      if (data_wr) begin
         unique case (off_q)
            `VTPG_OFS_CTL: cfg_d.ctl = wb_dat_i[7:0];
            `VTPG_OFS_CFG: cfg_d.cfg = wb_dat_i[7:0];
            `VTPG_OFS_DI: cfg_d.di = wb_dat_i[7:0];
            `VTPG_OFS_LSIZE_HI: cfg_d.lsize[15:8] = wb_dat_i[7:0];
            `VTPG_OFS_LSIZE_LO: cfg_d.lsize[7:0] = wb_dat_i[7:0];
            `VTPG_OFS_BAR_HI: cfg_d.bar[15:8] = wb_dat_i[7:0];
            `VTPG_OFS_BAR_LO: cfg_d.bar[7:0] = wb_dat_i[7:0];
            `VTPG_OFS_ACT_HI: cfg_d.act[15:8] = wb_dat_i[7:0];
            `VTPG_OFS_ACT_LO: cfg_d.act[7:0] = wb_dat_i[7:0];
            `VTPG_OFS_TOT_HI: cfg_d.tot[15:8] = wb_dat_i[7:0];
            `VTPG_OFS_TOT_LO: cfg_d.tot[7:0] = wb_dat_i[7:0];
            `VTPG_OFS_PD_HI: cfg_d.pd[15:8] = wb_dat_i[7:0];
            `VTPG_OFS_PD_LO: cfg_d.pd[7:0] = wb_dat_i[7:0];
            `VTPG_OFS_VBP: cfg_d.vbp = wb_dat_i[7:0];
            `VTPG_OFS_VFP: cfg_d.vfp = wb_dat_i[7:0];
            default: cfg_d = cfg_q;
         endcase
      end
      unique case (off_q)
         `VTPG_OFS_STATUS: field_rd = {5'h00, st_q};
         `VTPG_OFS_CTL: field_rd = cfg_q.ctl;
         `VTPG_OFS_CFG: field_rd = cfg_q.cfg;
         `VTPG_OFS_DI: field_rd = cfg_q.di;
         `VTPG_OFS_LSIZE_HI: field_rd = cfg_q.lsize[15:8];
         `VTPG_OFS_LSIZE_LO: field_rd = cfg_q.lsize[7:0];
         `VTPG_OFS_BAR_HI: field_rd = cfg_q.bar[15:8];
         `VTPG_OFS_BAR_LO: field_rd = cfg_q.bar[7:0];
         `VTPG_OFS_ACT_HI: field_rd = cfg_q.act[15:8];
         `VTPG_OFS_ACT_LO: field_rd = cfg_q.act[7:0];
         `VTPG_OFS_TOT_HI: field_rd = cfg_q.tot[15:8];
         `VTPG_OFS_TOT_LO: field_rd = cfg_q.tot[7:0];
         `VTPG_OFS_PD_HI: field_rd = cfg_q.pd[15:8];
         `VTPG_OFS_PD_LO: field_rd = cfg_q.pd[7:0];
         `VTPG_OFS_VBP: field_rd = cfg_q.vbp;
         `VTPG_OFS_VFP: field_rd = cfg_q.vfp;
         default: field_rd = `VTPG_RST_BYTE;
      endcase
      ack_d = req;
      dat_d = dat_q;
      if (req && !wb_we_i) begin
         if (idx == `VTPG_IDX_PAGE) begin
            dat_d = {24'h000000, page_q};
         end else if (idx == `VTPG_IDX_OFFSET) begin
            dat_d = {24'h000000, off_q};
         end else if (idx == `VTPG_IDX_DATA && page_q == `VTPG_PAGE_PGEN) begin
            dat_d = {24'h000000, field_rd};
         end else begin
            dat_d = 32'h00000000;
         end
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_q <= '0;
         page_q <= `VTPG_RST_BYTE;
         off_q <= `VTPG_RST_BYTE;
         ack_q <= 1'b0;
         dat_q <= 32'h00000000;
      end else begin
         cfg_q <= cfg_d;
         page_q <= page_d;
         off_q <= off_d;
         ack_q <= ack_d;
         dat_q <= dat_d;
      end
   end
   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
   // ----------------------------------------
   // Line period timer
   // ----------------------------------------
   logic [4:0] acc_q, acc_d, unit_ns, acc_sum;
   logic [15:0] pd_cnt_q, pd_cnt_d;
   logic en, tick, line_start;
   always_comb begin
      en = cfg_q.ctl[`VTPG_CTL_EN];
      unit_ns = cfg_q.ctl[`VTPG_CTL_SLOW] ? 5'(`VTPG_UNIT_SLOW_NS) : 5'(`VTPG_UNIT_NS);
      acc_sum = acc_q + 5'(`VTPG_CLK_NS);
      tick = acc_sum >= unit_ns;
      acc_d = tick ? acc_sum - unit_ns : acc_sum;
      line_start = 1'b0;
      pd_cnt_d = pd_cnt_q;
      if (tick) begin
         if (pd_cnt_q + 16'h0001 >= cfg_q.pd) begin
            pd_cnt_d = 16'h0000;
            line_start = 1'b1;
         end else begin
            pd_cnt_d = pd_cnt_q + 16'h0001;
         end
      end
      if (!en) begin
         acc_d = 5'h00;
         pd_cnt_d = 16'h0000;
      end
   end
   always_ff @(posedge clk_i) begin
      acc_q <= rst_i ? 5'h00 : acc_d;
      pd_cnt_q <= rst_i ? 16'h0000 : pd_cnt_d;
   end
   // ----------------------------------------
   // Packet sequencer
   // ----------------------------------------
   logic pend_q, pend_d, long_q, long_d, crc_clr, crc_en;
   logic [15:0] line_q, line_d, cnt_q, cnt_d, inbar_q, inbar_d;
   logic [31:0] hdr_q, hdr_d;
   logic [2:0] bar_q, bar_d, bar_last;
   logic [3:0] blk_q, blk_d;
   logic [7:0] pay, mem_rd;
   logic [15:0] crc;
   logic [17:0] act_end, fe_line, line_x;
   logic fixed;
   vtpg_byte_t out_q, out_d;
   always_comb begin
      fixed = cfg_q.cfg[`VTPG_CFG_FIXED];
      bar_last = 3'((4'h1 << cfg_q.cfg[`VTPG_CFG_NBAR_LSB +: 2]) - 4'h1);
      line_x = {2'b00, line_q};
      act_end = {10'h000, cfg_q.vbp} + {2'b00, cfg_q.act};
      fe_line = act_end + {10'h000, cfg_q.vfp} + 18'h00001;
      pay = fixed ? (mem_rd ^ {8{bar_q[0]}}) : bar_byte(bar_q);
      st_d = st_q;
      pend_d = pend_q;
      long_d = long_q;
      line_d = line_q;
      cnt_d = cnt_q;
      hdr_d = hdr_q;
      bar_d = bar_q;
      inbar_d = inbar_q;
      blk_d = blk_q;
      crc_clr = 1'b0;
      crc_en = 1'b0;
      out_d = '0;
      unique case (st_q)
         ST_IDLE: begin
            if (en) begin
               st_d = ST_WAIT;
               pend_d = 1'b1;
               line_d = 16'h0000;
            end
         end
         ST_WAIT: begin
            if (pend_q) begin
               pend_d = 1'b0;
               line_d = (line_q + 16'h0001 >= cfg_q.tot) ? 16'h0000 : line_q + 16'h0001;
               cnt_d = 16'h0000;
               if (line_q == 16'h0000) begin
                  hdr_d = hdr_word({cfg_q.di[7:6], `VTPG_DT_FS}, 16'h0000);
                  long_d = 1'b0;
                  st_d = ST_HDR;
               end else if (line_x > {10'h000, cfg_q.vbp} && line_x <= act_end) begin
                  hdr_d = hdr_word(cfg_q.di, cfg_q.lsize);
                  long_d = 1'b1;
                  st_d = ST_HDR;
               end else if (line_x == fe_line) begin
                  hdr_d = hdr_word({cfg_q.di[7:6], `VTPG_DT_FE}, 16'h0000);
                  long_d = 1'b0;
                  st_d = ST_HDR;
               end
            end
         end
         ST_HDR: begin
            out_d = '{valid: 1'b1, sop: cnt_q == 16'h0000, eop: !long_q && cnt_q == 16'h0003,
                      data: hdr_q[7:0]};
            hdr_d = hdr_q >> 8;
            cnt_d = cnt_q + 16'h0001;
            crc_clr = 1'b1;
            bar_d = 3'h0;
            inbar_d = 16'h0000;
            blk_d = 4'h0;
            if (cnt_q == 16'h0003) begin
               cnt_d = 16'h0000;
               st_d = !long_q ? ST_WAIT : (cfg_q.lsize == 16'h0000 ? ST_CRC : ST_PAY);
            end
         end
         ST_PAY: begin
            out_d = '{valid: 1'b1, sop: 1'b0, eop: 1'b0, data: pay};
            crc_en = 1'b1;
            cnt_d = cnt_q + 16'h0001;
            inbar_d = inbar_q + 16'h0001;
            // Only bar width matters here; whole-block widths are left to software
            if (inbar_q + 16'h0001 >= cfg_q.bar && bar_q < bar_last) begin
               bar_d = bar_q + 3'h1;
               inbar_d = 16'h0000;
            end
            blk_d = (blk_q >= cfg_q.cfg[`VTPG_CFG_BLK_LSB +: 4]) ? 4'h0 : blk_q + 4'h1;
            if (cnt_q + 16'h0001 >= cfg_q.lsize) begin
               cnt_d = 16'h0000;
               st_d = ST_CRC;
            end
         end
         ST_CRC: begin
            out_d = '{valid: 1'b1, sop: 1'b0, eop: cnt_q[0], data: cnt_q[0] ? crc[15:8] : crc[7:0]};
            cnt_d = cnt_q + 16'h0001;
            if (cnt_q[0]) begin
               cnt_d = 16'h0000;
               st_d = ST_WAIT;
            end
         end
         default: st_d = ST_IDLE;
      endcase
      // A start during a packet is held and served once the packet ends
      if (line_start) begin
         pend_d = 1'b1;
      end
      if (!en) begin
         st_d = ST_IDLE;
         pend_d = 1'b0;
         out_d = '0;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= ST_IDLE;
         pend_q <= 1'b0;
         long_q <= 1'b0;
         line_q <= 16'h0000;
         cnt_q <= 16'h0000;
         hdr_q <= 32'h00000000;
         bar_q <= 3'h0;
         inbar_q <= 16'h0000;
         blk_q <= 4'h0;
         out_q <= '0;
      end else begin
         st_q <= st_d;
         pend_q <= pend_d;
         long_q <= long_d;
         line_q <= line_d;
         cnt_q <= cnt_d;
         hdr_q <= hdr_d;
         bar_q <= bar_d;
         inbar_q <= inbar_d;
         blk_q <= blk_d;
         out_q <= out_d;
      end
   end
   assign pkt_o = out_q;
   // ----------------------------------------
   // Block store and checksum
   // ----------------------------------------
   vtpg_blk_mem u_mem (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .we_i(mem_we),
      .waddr_i(off_q[3:0]),
      .wdata_i(wb_dat_i[7:0]),
      .raddr_i(blk_d),
      .rdata_o(mem_rd)
   );
   vtpg_crc16 u_crc (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .clear_i(crc_clr),
      .en_i(crc_en),
      .data_i(pay),
      .crc_o(crc)
   );
endmodule : vtpg_top
`default_nettype wire

// *** sim/vtpg_properties.sv ***
// Purpose: Port level checks of the pattern generator
// Assumes: One clock domain, synchronous reset
// Notes:   Attached to vtpg_top by bind
`timescale 1ns/1ps
`default_nettype none
module vtpg_properties import vtpg_pkg::*; (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Stream
   input wire vtpg_byte_t pkt_o
);
   // ----------------------------------------
   // Sequences and checks
   // ----------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic req;
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   sequence s_short;
      pkt_o.valid && pkt_o.sop && pkt_o.data[5:1] == 5'h00;
   endsequence
   sequence s_long;
      pkt_o.valid && pkt_o.sop && pkt_o.data[5:1] != 5'h00;
   endsequence
   chk_ack_next: assert property (req |=> wb_ack_o)
      else $error("ack did not follow request");
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   chk_ack_cause: assert property (wb_ack_o |-> $past(req))
      else $error("ack without request");
   chk_rd_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
      else $error("read data upper bits set");
   chk_short_len: assert property (s_short |=> (pkt_o.valid && !pkt_o.sop && !pkt_o.eop) [*2]
      ##1 (pkt_o.valid && pkt_o.eop))
      else $error("short packet not four bytes");
   chk_short_wc: assert property (s_short |=> pkt_o.data == 8'h00 ##1 pkt_o.data == 8'h00)
      else $error("short packet word not zero");
   chk_long_body: assert property (s_long |=> (pkt_o.valid && !pkt_o.sop && !pkt_o.eop) [*4])
      else $error("long packet cut short");
   chk_ecc_top: assert property (pkt_o.valid && pkt_o.sop |-> ##3 pkt_o.data[7:6] == 2'b00)
      else $error("header check byte top bits set");
   chk_flags_valid: assert property ((pkt_o.sop || pkt_o.eop) |-> pkt_o.valid)
      else $error("packet flag without valid");
endmodule : vtpg_properties
bind vtpg_top vtpg_properties u_props (
   .clk_i(clk_i),
   .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i),
   .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o),
   .pkt_o(pkt_o)
);
`default_nettype wire

// *** sim/vtpg_sink.sv ***
// Purpose: Transmitter side model that records the packet stream
// Assumes: No backpressure; every valid byte is taken
// Notes:   Bench reads its queues directly
`timescale 1ns/1ps
`default_nettype none
module vtpg_sink import vtpg_pkg::*; (
   // Clock and stream
   input wire logic clk_i,
   input wire vtpg_byte_t pkt_i
);
   // ----------------------------------------
   // Capture
   // ----------------------------------------
   logic [7:0] b[$];
   int st[$];
   int ix[$];
   int cyc = 0;
   // Stamps each packet start so line spacing can be judged later
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (pkt_i.valid === 1'b1) begin
         if (pkt_i.sop === 1'b1) begin
            st.push_back(cyc);
            ix.push_back(b.size());
         end
         b.push_back(pkt_i.data);
      end
   end
endmodule : vtpg_sink
`default_nettype wire

// *** sim/testbench.sv ***
// Purpose: Self-checking bench of the pattern generator
// Assumes: Bus answers a request one cycle later
// Notes:   Short frames keep the run brief
`timescale 1ns/1ps
`default_nettype none
module testbench import vtpg_pkg::*;;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [11:0] wb_adr_i = 12'h000;
   logic [3:0] wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   vtpg_byte_t pkt_o;
   int failures = 0;
   int compares = 0;
   logic [31:0] rnd = 32'hea1a;
   logic [31:0] rd;
   logic [7:0] blk [16];
   logic [7:0] bars [8] = '{8'haa, 8'h33, 8'hf0, 8'h7f, 8'h55, 8'hcc, 8'h0f, 8'h80};
   always #4 clk_i = ~clk_i;
   vtpg_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pkt_o(pkt_o));
   vtpg_sink snk (.clk_i(clk_i), .pkt_i(pkt_o));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic complete_run();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : complete_run
   task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", n, e, g);
         failures++;
      end
   endtask : check
   // Accumulated period may land one cycle either side
   task automatic tcheck(input string n, input int e, input int g);
      compares++;
      if (g - e > 1 || e - g > 1) begin
         $display("mismatch %s expected %0d seen %0d", n, e, g);
         failures++;
      end
   endtask : tcheck
   task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d);
      int n;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= {24'h000000, d};
      for (n = 0; n < 20 && wb_ack_o !== 1'b1; n++) @(posedge clk_i);
      if (wb_ack_o !== 1'b1) begin
         failures++;
         complete_run();
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   task automatic fld(input logic [7:0] o, input logic [7:0] v);
      wb(1'b1, 12'h2c4, o);
      wb(1'b1, 12'h2c8, v);
   endtask : fld
   task automatic rdf(input logic [7:0] o);
      wb(1'b1, 12'h2c4, o);
      wb(1'b0, 12'h2c8, 8'h00);
   endtask : rdf
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   function automatic logic [15:0] bt(input int i);
      return {8'h00, snk.b[i]};
   endfunction : bt
   function automatic logic [7:0] expb(input int i, input logic [7:0] cf, input int bw);
      int k;
      k = i / bw;
      if (k > (1 << cf[5:4]) - 1) k = (1 << cf[5:4]) - 1;
      if (cf[7]) return blk[i % (cf[3:0] + 1)] ^ {8{k[0]}};
      return bars[k];
   endfunction : expb
   function automatic logic [15:0] crc(input int s);
      logic [15:0] c;
      c = 16'hffff;
      for (int i = 0; i < 20; i++) begin
         c = c ^ bt(s + i);
         for (int j = 0; j < 8; j++) c = c[0] ? ((c >> 1) ^ 16'h8408) : (c >> 1);
      end
      return c;
   endfunction : crc
   task automatic do_reset();
      rst_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      // Cleared once reset has stopped the stream, so no byte of the old frame slips in
      snk.b.delete();
      snk.st.delete();
      snk.ix.delete();
      rst_i <= 1'b0;
   endtask : do_reset
   // Frame: 20 byte lines, 2 active, 6 total, porches 1, period 32 units
   task automatic run(input logic [7:0] cf, input logic [7:0] ct, input logic [7:0] bw);
      int p;
      int s;
      do_reset();
      wb(1'b1, 12'h2c0, 8'h00);
      fld(8'h02, cf);
      fld(8'h03, 8'h6a);
      fld(8'h05, 8'h14);
      fld(8'h07, bw);
      fld(8'h09, 8'h02);
      fld(8'h0b, 8'h06);
      fld(8'h0d, 8'h20);
      fld(8'h0e, 8'h01);
      fld(8'h0f, 8'h01);
      for (int i = 0; i < 16; i++) fld(8'h10 + i[7:0], blk[i]);
      fld(8'h01, ct);
      for (int n = 0; n < 1500 && snk.st.size() < 5; n++) @(posedge clk_i);
      if (snk.st.size() < 5) begin
         failures++;
         complete_run();
      end
      p = ct[1] ? 80 : 40;
      s = snk.ix[1];
      check("fs_id", 16'h0040, bt(snk.ix[0]));
      check("line_id", 16'h006a, bt(s));
      check("line_wc", 16'h0014, bt(s + 1));
      check("line_wc_hi", 16'h0000, bt(s + 2));
      check("line2_id", 16'h006a, bt(snk.ix[2]));
      check("fe_id", 16'h0041, bt(snk.ix[3]));
      check("line_len", 16'd26, 16'(snk.ix[2] - s));
      for (int i = 0; i < 20; i++) check("payload", {8'h00, expb(i, cf, bw)}, bt(s + 4 + i));
      check("crc", crc(s + 4), {snk.b[s + 25], snk.b[s + 24]});
      tcheck("back_porch", 2 * p, snk.st[1] - snk.st[0]);
      tcheck("line_gap", p, snk.st[2] - snk.st[1]);
      tcheck("front_porch", 2 * p, snk.st[3] - snk.st[2]);
      tcheck("frame", 6 * p, snk.st[4] - snk.st[0]);
      $display("test cfg %h ctl %h done", cf, ct);
   endtask : run
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      for (int i = 0; i < 16; i++) begin
         rnd = lfsr(rnd);
         blk[i] = rnd[7:0];
      end
      do_reset();
      wb(1'b1, 12'h2c0, 8'h00);
      rdf(8'h00);
      check("status", 16'h0000, rd[15:0]);
      for (int o = 2; o < 16; o++) begin
         rnd = lfsr(rnd);
         fld(o[7:0], rnd[7:0]);
         rdf(o[7:0]);
         check("field", {8'h00, rnd[7:0]}, rd[15:0]);
      end
      fld(8'h0e, 8'h33);
      wb_sel_i <= 4'he;
      wb(1'b1, 12'h2c8, 8'h5a);
      wb_sel_i <= 4'hf;
      wb(1'b0, 12'h2c8, 8'h00);
      check("sel_ignored", 16'h0033, rd[15:0]);
      fld(8'h10, 8'hff);
      rdf(8'h10);
      check("block_read", 16'h0000, rd[15:0]);
      wb(1'b0, 12'h100, 8'h00);
      check("unmapped", 16'h0000, rd[15:0]);
      wb(1'b1, 12'h2c0, 8'h01);
      wb(1'b0, 12'h2c8, 8'h00);
      check("other_page", 16'h0000, rd[15:0]);
      $display("test registers done");
      for (int k = 0; k < 4; k++) run({2'b00, k[1:0], 4'h0}, 8'h01, 8'h02);
      run(8'h30, 8'h03, 8'h02);
      run(8'h94, 8'h01, 8'h0a);
      complete_run();
   end
endmodule : testbench
`default_nettype wire
